//--- inc/asu_pkg.sv
// constants of the async serial unit status and flag logic
package asu_pkg;
  // register indices, byte address is index times four
  localparam logic [3:0] IDX_BAUD_HI  = 4'h0;
  localparam logic [3:0] IDX_BAUD_LO  = 4'h1;
  localparam logic [3:0] IDX_CTL1     = 4'h2;
  localparam logic [3:0] IDX_ST1      = 4'h4;
  localparam logic [3:0] IDX_ST2      = 4'h5;
  localparam logic [3:0] IDX_DATA_HI  = 4'h6;
  localparam logic [3:0] IDX_DATA_LO  = 4'h7;
  localparam logic [3:0] IDX_EVT      = 4'h8;
  localparam logic [3:0] IDX_MASK     = 4'h9;
  localparam int         IDX_W        = 4;
  // serial_status_two fields
  localparam int ST2_BANK_BIT  = 7;
  localparam int ST2_TXINV_BIT = 4;
  localparam int ST2_RXINV_BIT = 3;
  localparam int ST2_LONG_BREAK_SEL_BIT = 2;
  localparam int ST2_DIR_BIT   = 1;
  localparam int ST2_RAF_BIT   = 0;
  localparam logic [7:0] ST2_WR_MASK = 8'h9e;
  localparam logic [7:0] ST2_RESET   = 8'h00;
  // serial_control_one fields
  localparam int CTL1_LOOP_BIT = 7;
  localparam int CTL1_RSRC_BIT = 5;
  localparam int CTL1_M_BIT    = 4;
  localparam int CTL1_IREN_BIT = 1;
  // serial_status_one fields
  localparam int ST1_TX_EMPTY_FLAG_BIT = 7;
  localparam int ST1_TC_BIT   = 6;
  localparam int ST1_RX_FULL_FLAG_BIT = 5;
  localparam int ST1_IDLE_BIT = 4;
  localparam int ST1_OR_BIT   = 3;
  // serial_data_high fields
  localparam int DHI_R8_BIT = 7;
  localparam int DHI_T8_BIT = 6;
  // flag vector positions for arming and events
  localparam int FLG_TX_EMPTY_FLAG = 0;
  localparam int FLG_TC   = 1;
  localparam int FLG_RX_FULL_FLAG = 2;
  localparam int FLG_IDLE = 3;
  localparam int FLG_OR   = 4;
  localparam int FLG_N    = 5;
  localparam logic [4:0] FLG_RESET = 5'h03;
  // idle character and break lengths in bit times
  localparam logic [3:0] IDLE_ONES_8 = 4'ha;
  localparam logic [3:0] IDLE_ONES_9 = 4'hb;
  localparam logic [3:0] BRK_SHORT_8 = 4'ha;
  localparam logic [3:0] BRK_SHORT_9 = 4'hb;
  localparam logic [3:0] BRK_LONG_8  = 4'hd;
  localparam logic [3:0] BRK_LONG_9  = 4'he;
  // ahb transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- src/asu_line_enc.sv
// transmit pin encoder for nrz and infrared formats
`timescale 1ns/10ps
module asu_line_enc
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic data_bit,
  input  wire logic ir_mode,
  input  wire logic invert,
  input  wire logic ir_pulse,
  input  wire logic hold_idle,
  input  wire logic drive,
  output logic      pin,
  output logic      pin_oe_n
);
  logic b;
  logic lvl_d;

  always_comb
  begin
    b = hold_idle | data_bit;
    if (ir_mode)
      lvl_d = (~b & ir_pulse) ^ invert;
    else
      lvl_d = b ^ invert;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin      <= 1'b1;
      pin_oe_n <= 1'b0;
    end
    else
    begin
      pin      <= lvl_d;
      pin_oe_n <= ~drive;
    end
  end
endmodule

//--- src/asu_serial_flags.sv
// status, configuration and interrupt flags of the async serial unit
`timescale 1ns/10ps
module asu_serial_flags
  import asu_pkg::*;
#(
  parameter int IDLE_CNT_W = 4
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        tx_raw_bit,
  input  wire logic        tx_ir_pulse,
  input  wire logic        tx_took,
  input  wire logic        tx_busy,
  input  wire logic        tx_queue_req,
  input  wire logic        rx_pin,
  input  wire logic        tx_pin_in,
  input  wire logic        rx_first_slot,
  input  wire logic        rx_bit_tick,
  input  wire logic        rx_frame_done,
  input  wire logic [8:0]  rx_frame_data,
  output logic             tx_pin,
  output logic             tx_pin_oe_n,
  output logic             rx_level,
  output logic [8:0]       tx_data,
  output logic             tx_empty,
  output logic [3:0]       break_len,
  output logic [15:0]      baud_div,
  output logic             irq
);
  if (IDLE_CNT_W < 4)
    $error("IDLE_CNT_W too small for idle count");

  logic [7:0]          baud_hi_q, baud_lo_q, ctl1_q, sr2_q;
  logic [7:0]          alt_st1_q, alt_ctl1_q, alt_ctl2_q;
  logic                tx_empty_flag_q, tc_q, rx_full_flag_q, ovr_q, idle_q, raf_q;
  logic [FLG_N-1:0]    arm_q, evt_q, mask_q, flg_prev_q;
  logic [8:0]          rx_data_q, tx_data_q;
  logic [IDLE_CNT_W-1:0] idle_cnt_q;
  logic                idle_arm_q;
  logic                pend_q, pend_wr_q;
  logic [IDX_W-1:0]    pend_idx_q;
  logic                rx_level_q;
  logic [3:0]          break_len_q;
  logic                irq_q, hreadyout_q, hresp_q;
  logic [31:0]         hrdata_q;
  logic [7:0]          rd_byte;
  logic [15:0]         wr_sel, rd_sel;
  logic [7:0]          wdat;
  logic                accept, bank, single_wire, ir_mode, nine_bit;
  logic                rx_src, rx_bit, idle_hit, queued;
  logic [3:0]          idle_target;
  logic [FLG_N-1:0]    flg, flg_rise;

  // assemble serial_status_one
  function automatic logic [7:0] st1_byte(input logic [FLG_N-1:0] f);
    logic [7:0] v;
    v               = 8'h00;
    v[ST1_TX_EMPTY_FLAG_BIT] = f[FLG_TX_EMPTY_FLAG];
    v[ST1_TC_BIT]   = f[FLG_TC];
    v[ST1_RX_FULL_FLAG_BIT] = f[FLG_RX_FULL_FLAG];
    v[ST1_IDLE_BIT] = f[FLG_IDLE];
    v[ST1_OR_BIT]   = f[FLG_OR];
    return v;
  endfunction

  assign flg         = {ovr_q, idle_q, rx_full_flag_q, tc_q, tx_empty_flag_q};
  assign bank        = sr2_q[ST2_BANK_BIT];
  assign single_wire = ctl1_q[CTL1_LOOP_BIT] & ctl1_q[CTL1_RSRC_BIT];
  assign ir_mode     = ctl1_q[CTL1_IREN_BIT];
  assign nine_bit    = ctl1_q[CTL1_M_BIT];
  assign wdat        = hwdata[7:0];
  assign accept      = hsel & hready & hreadyout_q & (htrans == HTRANS_NONSEQ);
  assign wr_sel      = (pend_q & pend_wr_q) ? (16'h0001 << pend_idx_q) : 16'h0000;
  assign rd_sel      = (pend_q & ~pend_wr_q) ? (16'h0001 << pend_idx_q) : 16'h0000;

  // bus handshake: one wait cycle, then data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pend_q      <= 1'b0;
      pend_wr_q   <= 1'b0;
      pend_idx_q  <= '0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
    else
    begin
      pend_q      <= accept & (haddr[31:6] == '0) & (haddr[1:0] == 2'h0);
      pend_wr_q   <= hwrite;
      pend_idx_q  <= haddr[5:2];
      hreadyout_q <= ~accept;
      hresp_q     <= 1'b0;
    end
  end

  // read mux
  always_comb
  begin
    rd_byte = 8'h00;
    if (pend_idx_q == IDX_BAUD_HI)
      rd_byte = bank ? alt_st1_q : baud_hi_q;
    else if (pend_idx_q == IDX_BAUD_LO)
      rd_byte = bank ? alt_ctl1_q : baud_lo_q;
    else if (pend_idx_q == IDX_CTL1)
      rd_byte = bank ? alt_ctl2_q : ctl1_q;
    else if (pend_idx_q == IDX_ST1)
      rd_byte = st1_byte(flg);
    else if (pend_idx_q == IDX_ST2)
      rd_byte = {sr2_q[7:1], raf_q};
    else if (pend_idx_q == IDX_DATA_HI)
      rd_byte = {rx_data_q[8], tx_data_q[8], 6'h00};
    else if (pend_idx_q == IDX_DATA_LO)
      rd_byte = rx_data_q[7:0];
    else if (pend_idx_q == IDX_EVT)
      rd_byte = {3'h0, evt_q};
    else if (pend_idx_q == IDX_MASK)
      rd_byte = {3'h0, mask_q};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      hrdata_q <= '0;
    else if (rd_sel != 16'h0000)
      hrdata_q <= {24'h000000, rd_byte};
  end

  // configuration registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      baud_hi_q  <= 8'h00;
      baud_lo_q  <= 8'h00;
      ctl1_q     <= 8'h00;
      alt_st1_q  <= 8'h00;
      alt_ctl1_q <= 8'h00;
      alt_ctl2_q <= 8'h00;
      sr2_q      <= ST2_RESET;
      mask_q     <= '0;
    end
    else
    begin
      if (wr_sel[IDX_BAUD_HI] & bank)
        alt_st1_q <= wdat;
      else if (wr_sel[IDX_BAUD_HI])
        baud_hi_q <= wdat;
      if (wr_sel[IDX_BAUD_LO] & bank)
        alt_ctl1_q <= wdat;
      else if (wr_sel[IDX_BAUD_LO])
        baud_lo_q <= wdat;
      if (wr_sel[IDX_CTL1] & bank)
        alt_ctl2_q <= wdat;
      else if (wr_sel[IDX_CTL1])
        ctl1_q <= wdat;
      if (wr_sel[IDX_ST2])
        sr2_q <= wdat & ST2_WR_MASK;
      if (wr_sel[IDX_MASK])
        mask_q <= wdat[FLG_N-1:0];
    end
  end

  // two-step clear arming
  always_ff @(posedge clk)
  begin
    if (rst)
      arm_q <= '0;
    else
    begin
      if (rd_sel[IDX_ST1])
        arm_q <= flg;
      else
      begin
        if (wr_sel[IDX_DATA_LO])
        begin
          arm_q[FLG_TX_EMPTY_FLAG] <= 1'b0;
          arm_q[FLG_TC]   <= 1'b0;
        end
        if (rd_sel[IDX_DATA_LO])
        begin
          arm_q[FLG_RX_FULL_FLAG] <= 1'b0;
          arm_q[FLG_IDLE] <= 1'b0;
          arm_q[FLG_OR]   <= 1'b0;
        end
      end
    end
  end

  // transmit flags
  assign queued = tx_queue_req | wr_sel[IDX_DATA_LO];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_empty_flag_q    <= 1'b1;
      tc_q      <= 1'b1;
      tx_data_q <= '0;
    end
    else
    begin
      if (wr_sel[IDX_DATA_LO])
        tx_data_q[7:0] <= wdat;
      if (wr_sel[IDX_DATA_HI])
        tx_data_q[8] <= wdat[DHI_T8_BIT];
      if (tx_took)
        tx_empty_flag_q <= 1'b1;
      else if (wr_sel[IDX_DATA_LO] & arm_q[FLG_TX_EMPTY_FLAG])
        tx_empty_flag_q <= 1'b0;
      if (tx_empty_flag_q & ~tx_busy & ~queued)
        tc_q <= 1'b1;
      else if (queued)
        tc_q <= 1'b0;
    end
  end

  // receive path
  assign rx_src      = single_wire ? tx_pin_in : rx_pin;
  assign rx_bit      = ir_mode ? ~(rx_src ^ sr2_q[ST2_RXINV_BIT])
                               : (rx_src ^ sr2_q[ST2_RXINV_BIT]);
  assign idle_target = nine_bit ? IDLE_ONES_9 : IDLE_ONES_8;
  assign idle_hit    = rx_bit_tick & rx_bit
                     & (idle_cnt_q == IDLE_CNT_W'(idle_target - 4'h1));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_full_flag_q    <= 1'b0;
      ovr_q     <= 1'b0;
      rx_data_q <= '0;
    end
    else
    begin
      if (rx_frame_done & ~rx_full_flag_q)
      begin
        rx_full_flag_q    <= 1'b1;
        rx_data_q <= rx_frame_data;
      end
      else if (rd_sel[IDX_DATA_LO] & arm_q[FLG_RX_FULL_FLAG])
        rx_full_flag_q <= 1'b0;
      if (rx_frame_done & rx_full_flag_q)
        ovr_q <= 1'b1;
      else if (rd_sel[IDX_DATA_LO] & arm_q[FLG_OR])
        ovr_q <= 1'b0;
    end
  end

  // idle detection
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      idle_cnt_q <= '0;
      idle_arm_q <= 1'b1;
      idle_q     <= 1'b0;
    end
    else
    begin
      if (rx_bit_tick & ~rx_bit)
        idle_cnt_q <= '0;
      else if (rx_bit_tick & (idle_cnt_q < IDLE_CNT_W'(idle_target)))
        idle_cnt_q <= idle_cnt_q + 1'b1;
      if (rx_frame_done & ~rx_full_flag_q)
        idle_arm_q <= 1'b1;
      else if (idle_hit)
        idle_arm_q <= 1'b0;
      if (idle_hit & idle_arm_q)
        idle_q <= 1'b1;
      else if (rd_sel[IDX_DATA_LO] & arm_q[FLG_IDLE])
        idle_q <= 1'b0;
    end
  end

  // receiver active flag
  always_ff @(posedge clk)
  begin
    if (rst)
      raf_q <= 1'b0;
    else if (rx_first_slot & ~rx_bit)
      raf_q <= 1'b1;
    else if (idle_hit)
      raf_q <= 1'b0;
  end

  // sticky events, write one to clear, set wins
  assign flg_rise = flg & ~flg_prev_q;

  for (genvar g = 0; g < FLG_N; g++)
  begin : g_evt
    always_ff @(posedge clk)
    begin
      if (rst)
        evt_q[g] <= 1'b0;
      else if (flg_rise[g])
        evt_q[g] <= 1'b1;
      else if (wr_sel[IDX_EVT] & wdat[g])
        evt_q[g] <= 1'b0;
    end
  end

  // line side outputs and interrupt
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flg_prev_q  <= FLG_RESET;
      irq_q       <= 1'b0;
      rx_level_q  <= 1'b1;
      break_len_q <= BRK_SHORT_8;
    end
    else
    begin
      flg_prev_q <= flg;
      irq_q      <= |(evt_q & mask_q);
      rx_level_q <= rx_bit;
      if (sr2_q[ST2_LONG_BREAK_SEL_BIT])
        break_len_q <= nine_bit ? BRK_LONG_9 : BRK_LONG_8;
      else
        break_len_q <= nine_bit ? BRK_SHORT_9 : BRK_SHORT_8;
    end
  end

  asu_line_enc u_enc
  (
    .clk       (clk),
    .rst       (rst),
    .data_bit  (tx_raw_bit),
    .ir_mode   (ir_mode),
    .invert    (sr2_q[ST2_TXINV_BIT]),
    .ir_pulse  (tx_ir_pulse),
    .hold_idle (tc_q),
    .drive     (~single_wire | sr2_q[ST2_DIR_BIT]),
    .pin       (tx_pin),
    .pin_oe_n  (tx_pin_oe_n)
  );

  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = hresp_q;
  assign rx_level  = rx_level_q;
  assign tx_data   = tx_data_q;
  assign tx_empty  = tx_empty_flag_q;
  assign break_len = break_len_q;
  assign baud_div  = {baud_hi_q, baud_lo_q};
  assign irq       = irq_q;

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  a_bank_read: assert property (
    rd_sel[IDX_BAUD_HI] & bank |=> hrdata[7:0] == $past(alt_st1_q))
    else $error("bank select read wrong");
  a_tx_polarity: assert property (
    ~tc_q & ~ir_mode |=> tx_pin == $past(tx_raw_bit ^ sr2_q[ST2_TXINV_BIT]))
    else $error("transmit polarity wrong");
  a_rx_polarity: assert property (
    ~ir_mode & ~single_wire |=> rx_level == $past(rx_pin ^ sr2_q[ST2_RXINV_BIT]))
    else $error("receive polarity wrong");
  a_break_long: assert property (
    sr2_q[ST2_LONG_BREAK_SEL_BIT] & ~nine_bit ##1 $stable(sr2_q) & $stable(ctl1_q)
    |-> break_len == BRK_LONG_8)
    else $error("break length wrong");
  a_pin_dir: assert property (
    ~single_wire |=> ~tx_pin_oe_n)
    else $error("pin not driven outside single wire");
  a_raf_set: assert property (
    rx_first_slot & ~rx_bit |=> raf_q)
    else $error("active flag not set");
  a_irq_or: assert property (
    (evt_q & mask_q) != '0 |=> irq)
    else $error("interrupt not raised");
  a_tx_empty_flag_set: assert property (
    tx_took |=> tx_empty_flag_q)
    else $error("tx empty not set");
  a_tc_idle: assert property (
    tc_q & ~ir_mode |=> tx_pin == ~$past(sr2_q[ST2_TXINV_BIT]))
    else $error("pin not idle while complete");
  a_tc_clear: assert property (
    tx_queue_req |=> ~tc_q)
    else $error("tx complete not cleared");
  a_rx_full_flag_load: assert property (
    rx_frame_done & ~rx_full_flag_q |=> rx_full_flag_q && rx_data_q == $past(rx_frame_data))
    else $error("receive transfer wrong");
  a_overrun: assert property (
    rx_frame_done & rx_full_flag_q |=> ovr_q && $stable(rx_data_q))
    else $error("overrun handling wrong");
  a_idle_gate: assert property (
    ~idle_arm_q & ~idle_q |=> ~idle_q)
    else $error("idle set without frame");
  a_st2_write: assert property (
    wr_sel[IDX_ST2] |=> sr2_q == $past(wdat & ST2_WR_MASK))
    else $error("status two write lost");
  a_two_step: assert property (
    $fell(rx_full_flag_q) |-> $past(arm_q[FLG_RX_FULL_FLAG] & rd_sel[IDX_DATA_LO]))
    else $error("rx full cleared without sequence");
  a_bus_wait: assert property (
    accept |=> ~hreadyout ##1 hreadyout)
    else $error("bus answer timing wrong");

  c_overrun: cover property (rx_frame_done & rx_full_flag_q);
  c_idle:    cover property ($rose(idle_q));
  c_irq:     cover property ($rose(irq));
  c_bank:    cover property (rd_sel[IDX_CTL1] & bank);
endmodule

//--- testbench/asu_remote_node.sv
// remote serial node model driving the receive side of the line
`timescale 1ns/10ps
module asu_remote_node
(
  input  wire logic       clk,
  output logic            rx_pin,
  output logic            rx_bit_tick,
  output logic            rx_first_slot,
  output logic            rx_frame_done,
  output logic [8:0]      rx_frame_data
);
  initial
  begin
    rx_pin = 1'b1;
    rx_bit_tick = 1'b0;
    rx_first_slot = 1'b0;
    rx_frame_done = 1'b0;
    rx_frame_data = 9'h1aa;
  end
  task automatic set_level(input logic b);
    @(posedge clk);
    rx_pin <= b;
  endtask
  task automatic tick(input logic b);
    set_level(b);
    @(posedge clk);
    rx_bit_tick <= 1'b1;
    @(posedge clk);
    rx_bit_tick <= 1'b0;
  endtask
  task automatic send_ones(input int n);
    repeat (n) tick(1'b1);
  endtask
  task automatic send_frame(input logic [7:0] d);
    set_level(1'b0);
    @(posedge clk);
    rx_first_slot <= 1'b1;
    @(posedge clk);
    rx_first_slot <= 1'b0;
    tick(1'b0);
    for (int i = 0; i < 8; i++) tick(d[i]);
    tick(1'b1);
    @(posedge clk);
    rx_frame_done <= 1'b1;
    rx_frame_data <= {1'b0, d};
    @(posedge clk);
    rx_frame_done <= 1'b0;
    rx_frame_data <= ~{1'b0, d};
  endtask
endmodule

//--- testbench/tb.sv
// self-checking bench of the serial status and flag block
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
  import asu_pkg::*;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp, irq, tx_empty, rx_level;
  logic        tx_raw_bit, tx_ir_pulse, tx_took, tx_busy, tx_queue_req, rx_pin, tx_pin_in;
  logic        rx_first_slot, rx_bit_tick, rx_frame_done, tx_pin, tx_pin_oe_n;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [8:0]  rx_frame_data, tx_data;
  logic [3:0]  break_len;
  logic [15:0] baud_div;
  logic [7:0]  rd;
  int          failures, samples_checked, cycles;
  assign hready = hreadyout;
  assign tx_pin_in = tx_pin;
  asu_serial_flags #(.IDLE_CNT_W(4)) u_dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .tx_raw_bit, .tx_ir_pulse,
    .tx_took, .tx_busy, .tx_queue_req, .rx_pin, .tx_pin_in, .rx_first_slot, .rx_bit_tick,
    .rx_frame_done, .rx_frame_data, .tx_pin, .tx_pin_oe_n, .rx_level, .tx_data, .tx_empty,
    .break_len, .baud_div, .irq);
  asu_remote_node u_node (.clk, .rx_pin, .rx_bit_tick, .rx_first_slot, .rx_frame_done,
    .rx_frame_data);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] st1_rx(input logic full, input logic idle, input logic ovr);
    return {2'b00, full, idle, ovr, 3'b000};
  endfunction
  function automatic logic [3:0] brk(input logic lng, input logic nine);
    return lng ? (nine ? BRK_LONG_9 : BRK_LONG_8) : (nine ? BRK_SHORT_9 : BRK_SHORT_8);
  endfunction
  // expected pin level: nrz mark/space or infrared mid-bit pulse for a zero
  function automatic logic enc(input logic ir, input logic inv, input logic b, input logic p);
    return ir ? ((p & ~b) ^ inv) : (b ^ inv);
  endfunction
  task automatic close_out();
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {26'h0, idx, 2'h0};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    cycles = 0;
    failures = 0;
    samples_checked = 0;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      close_out();
    end
  end
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tx_raw_bit = 1'b1;
    tx_ir_pulse = 1'b0;
    tx_took = 1'b0;
    tx_busy = 1'b0;
    tx_queue_req = 1'b0;
    rnd = 32'hebe6;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("break_len", brk(1'b0, 1'b0), break_len)
    `CHK("tx_pin", 1'b1, tx_pin)
    bus(1'b0, IDX_ST1, 8'h0);
    `CHK("st1", 8'hc0, rd)
    `CHK("hresp", 1'b0, hresp)
    rnd = lfsr(rnd);
    bus(1'b1, IDX_ST2, rnd[7:0] | 8'h01);
    bus(1'b0, IDX_ST2, 8'h0);
    `CHK("st2", rnd[7:0] & ST2_WR_MASK, rd)
    bus(1'b1, IDX_ST2, 8'h00);
    bus(1'b1, IDX_BAUD_HI, 8'h12);
    bus(1'b1, IDX_BAUD_LO, 8'h34);
    bus(1'b1, IDX_ST2, 8'h80);
    bus(1'b1, IDX_BAUD_HI, 8'h5a);
    bus(1'b1, IDX_CTL1, 8'h3c);
    bus(1'b0, IDX_BAUD_HI, 8'h0);
    `CHK("alt_st1", 8'h5a, rd)
    bus(1'b0, IDX_CTL1, 8'h0);
    `CHK("alt_ctl2", 8'h3c, rd)
    `CHK("baud_div", 16'h1234, baud_div)
    bus(1'b1, IDX_ST2, 8'h00);
    bus(1'b0, IDX_BAUD_HI, 8'h0);
    `CHK("baud_hi", 8'h12, rd)
    bus(1'b0, IDX_CTL1, 8'h0);
    `CHK("ctl1", 8'h00, rd)
    bus(1'b0, 4'h3, 8'h0);
    `CHK("unmapped", 8'h00, rd)
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, IDX_CTL1, {3'b000, i[1], 4'h0});
      bus(1'b1, IDX_ST2, {5'b00000, i[0], 2'b00});
      @(posedge clk);
      `CHK("break_len", brk(i[0], i[1]), break_len)
    end
    bus(1'b1, IDX_CTL1, 8'ha0);
    @(posedge clk);
    `CHK("tx_pin_oe_n", 1'b1, tx_pin_oe_n)
    bus(1'b1, IDX_ST2, 8'h02);
    @(posedge clk);
    `CHK("tx_pin_oe_n", 1'b0, tx_pin_oe_n)
    bus(1'b1, IDX_CTL1, 8'h00);
    repeat (4)
    begin
      rnd = lfsr(rnd);
      bus(1'b1, IDX_ST2, {4'h0, rnd[0], 3'b000});
      u_node.set_level(rnd[1]);
      repeat (2) @(posedge clk);
      `CHK("rx_level", rnd[1] ^ rnd[0], rx_level)
    end
    u_node.set_level(1'b1);
    bus(1'b0, IDX_ST1, 8'h0);
    bus(1'b1, IDX_DATA_LO, 8'h55);
    `CHK("tx_empty", 1'b0, tx_empty)
    tx_busy <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, IDX_CTL1, {6'h00, i[2], 1'b0});
      bus(1'b1, IDX_ST2, {3'b000, i[0], 4'h0});
      rnd = lfsr(rnd);
      tx_raw_bit <= i[1];
      tx_ir_pulse <= rnd[0];
      repeat (3) @(posedge clk);
      `CHK("tx_pin", enc(i[2], i[0], i[1], rnd[0]), tx_pin)
    end
    bus(1'b1, IDX_CTL1, 8'h00);
    bus(1'b1, IDX_ST2, 8'h00);
    tx_took <= 1'b1;
    @(posedge clk);
    tx_took <= 1'b0;
    @(posedge clk);
    `CHK("tx_empty", 1'b1, tx_empty)
    `CHK("tx_data", 9'h055, tx_data)
    bus(1'b0, IDX_ST1, 8'h0);
    `CHK("st1_tx", 8'h80, rd & 8'hc0)
    tx_busy <= 1'b0;
    tx_raw_bit <= 1'b0;
    repeat (2) @(posedge clk);
    bus(1'b0, IDX_ST1, 8'h0);
    `CHK("st1_tx", 8'hc0, rd & 8'hc0)
    `CHK("tx_pin", 1'b1, tx_pin)
    tx_queue_req <= 1'b1;
    tx_busy <= 1'b1;
    @(posedge clk);
    tx_queue_req <= 1'b0;
    bus(1'b0, IDX_ST1, 8'h0);
    `CHK("st1_tc", 8'h00, rd & 8'h40)
    tx_busy <= 1'b0;
    bus(1'b1, IDX_EVT, 8'h1f);
    bus(1'b1, IDX_MASK, 8'h04);
    rnd = lfsr(rnd);
    u_node.send_frame(rnd[7:0]);
    repeat (3) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    bus(1'b0, IDX_ST2, 8'h0);
    `CHK("rx_active", 1'b1, rd[0])
    bus(1'b0, IDX_DATA_LO, 8'h0);
    bus(1'b0, IDX_ST1, 8'h0);
    `CHK("st1_rx", st1_rx(1'b1, 1'b0, 1'b0), rd & 8'h38)
    u_node.send_frame(rnd[15:8]);
    bus(1'b0, IDX_ST1, 8'h0);
    `CHK("st1_rx", st1_rx(1'b1, 1'b0, 1'b1), rd & 8'h38)
    bus(1'b0, IDX_DATA_LO, 8'h0);
    `CHK("data_lo", rnd[7:0], rd)
    bus(1'b0, IDX_ST1, 8'h0);
    `CHK("st1_rx", st1_rx(1'b0, 1'b0, 1'b0), rd & 8'h38)
    bus(1'b1, IDX_EVT, 8'h04);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    u_node.send_ones(10);
    bus(1'b0, IDX_ST1, 8'h0);
    `CHK("st1_rx", st1_rx(1'b0, 1'b1, 1'b0), rd & 8'h38)
    bus(1'b0, IDX_ST2, 8'h0);
    `CHK("rx_active", 1'b0, rd[0])
    bus(1'b0, IDX_DATA_LO, 8'h0);
    u_node.tick(1'b0);
    u_node.send_ones(10);
    bus(1'b0, IDX_ST1, 8'h0);
    `CHK("st1_rx", st1_rx(1'b0, 1'b0, 1'b0), rd & 8'h38)
    u_node.send_frame(rnd[23:16]);
    u_node.send_ones(10);
    bus(1'b0, IDX_ST1, 8'h0);
    `CHK("st1_rx", st1_rx(1'b1, 1'b1, 1'b0), rd & 8'h38)
    close_out();
  end
endmodule
